// File: core/timer8_pkg.sv
package timer8_pkg;

  // Bus geometry
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_COUNT   = 8'h04;
  localparam logic [7:0]  OFF_CMP_A   = 8'h08;
  localparam logic [7:0]  OFF_CMP_B   = 8'h0C;
  localparam logic [7:0]  OFF_FLAGS   = 8'h10;
  localparam logic [7:0]  OFF_STATUS  = 8'h14;

  // Control register: low byte is ctrl_t, force strobes above it
  localparam int          CTRL_FORCE_A = 9;
  localparam int          CTRL_FORCE_B = 8;

  // Flag register bit positions
  localparam int          FLAG_OVF    = 0;
  localparam int          FLAG_CMP_A  = 1;
  localparam int          FLAG_CMP_B  = 2;
  localparam int          STAT_DOWN   = 0;

  // Count range
  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [7:0]  CNT_BOTTOM  = 8'h00;
  localparam logic [7:0]  CNT_ONE     = 8'h01;

  // Waveform mode selector codes
  localparam logic [2:0]  MODE_NORMAL    = 3'h0;
  localparam logic [2:0]  MODE_PHASE_MAX = 3'h1;
  localparam logic [2:0]  MODE_CTC       = 3'h2;
  localparam logic [2:0]  MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0]  MODE_PHASE_CMP = 3'h5;
  localparam logic [2:0]  MODE_FAST_CMP  = 3'h7;

  // Output action selector codes
  localparam logic [1:0]  ACT_OFF     = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
  localparam logic [1:0]  ACT_CLEAR   = 2'h2;
  localparam logic [1:0]  ACT_SET     = 2'h3;

  // Reset values
  localparam logic [7:0]  CMP_RST     = 8'h00;
  localparam logic [2:0]  FLAGS_RST   = 3'h0;

  typedef struct packed {
    logic [1:0] output_action_a;
    logic [1:0] output_action_b;
    logic       pad;
    logic [2:0] waveform_mode_sel;
  } ctrl_t;

  localparam ctrl_t       CTRL_RST    = '{ACT_OFF, ACT_OFF, 1'b0, MODE_NORMAL};

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

endpackage : timer8_pkg

// File: core/timer8_waveform_modes.sv
// What this block does
// - Mode picks counting; action picks output only
// - Normal mode counts up, wraps max to zero
// - Overflow set as count goes max to zero, non-PWM
// - Clear-on-match resets count at compare A
// - Missed match runs to max and wraps
// - Compare A flag at each clear-on-match top
// - Toggle action inverts output A each match
// - Fast PWM top is max or compare A
// - Fast PWM counts to top, then clears
// - Fast PWM clear/set polarity at match and bottom
// - Fast PWM overflow flag at top
// - Fast PWM toggle only channel A, upper bit
// - Fast PWM extremes: spike or constant level
// - Fast PWM compare goes through double buffer
// - Phase PWM top is max or compare A
// - Phase PWM reverses at top, one tick
// - Phase PWM overflow flag at bottom
// - Phase PWM up/down match polarity
// - Phase PWM toggle only channel A, upper bit
// - Phase PWM extremes give constant levels
// - Phase PWM bottom transition keeps symmetry
// - Periods 510 or 256 ticks at fixed top
// - Match flag next tick; write-one or ack clears
// - PWM compare buffered; others write directly
// - Count write wins and blocks next match
//
// The APB slave port and the register offsets are this design's own decisions.
module timer8_waveform_modes (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        timer_tick,
  input  wire logic [2:0]  flag_service_ack,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             overflow_flag,
  output logic             compare_a_flag,
  output logic             compare_b_flag
);

  timer8_pkg::ctrl_t ctrl_q;
  timer8_pkg::dir_t  dir_q;
  timer8_pkg::dir_t  dir_d;
  logic [7:0]        count_value_q;
  logic [7:0]        count_value_d;
  logic              block_q;
  logic [2:0]        flags_q;
  logic [2:0]        flags_d;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic [7:0]        buf_q [2];
  logic [7:0]        act_q [2];
  logic [7:0]        cmp_eff [2];
  logic              wave_q [2];
  logic              pend_q [2];
  logic              hit [2];
  logic              force_cmp [2];
  logic              sel_cmp [2];

  // Bus timing
  // Setup cycle: psel high, penable low, nothing decoded yet
  // First access edge: pready_q is loaded, read data captured
  // Second access edge: pready_q high, a write takes effect here
  // The wait state costs one cycle per access but keeps
  // prdata, pready and pslverr straight from flops
  // Unmapped offsets answer with pslverr and change nothing
  // A low clock enable stalls the slave with its state held
  // Back-to-back transfers are fine: pready_q drops after done

  // APB decode; one wait state so every answer comes from flops
  wire         access    = psel & penable;
  wire         first     = access & ~pready_q;
  wire         done      = access & pready_q;
  wire         sel_ctrl  = paddr == timer8_pkg::OFF_CTRL;
  wire         sel_cnt   = paddr == timer8_pkg::OFF_COUNT;
  wire         sel_flags = paddr == timer8_pkg::OFF_FLAGS;
  wire         sel_stat  = paddr == timer8_pkg::OFF_STATUS;
  assign sel_cmp[0] = paddr == timer8_pkg::OFF_CMP_A;
  assign sel_cmp[1] = paddr == timer8_pkg::OFF_CMP_B;
  wire         mapped    = sel_ctrl | sel_cnt | sel_flags | sel_stat
                         | sel_cmp[0] | sel_cmp[1];
  wire         wr        = done & pwrite & mapped;
  wire         cnt_wr    = wr & sel_cnt;
  wire         ctrl_wr   = wr & sel_ctrl;
  wire         flag_wr   = wr & sel_flags;

  // Read data mux; unmapped and write-only bits read zero
  wire [31:0]  rdata =
      sel_ctrl   ? {24'h000000, ctrl_q}
    : sel_cnt    ? {24'h000000, count_value_q}
    : sel_cmp[0] ? {24'h000000, buf_q[0]}
    : sel_cmp[1] ? {24'h000000, buf_q[1]}
    : sel_flags  ? {29'h00000000, flags_q}
    : sel_stat   ? {31'h00000000, dir_q == timer8_pkg::DIR_DOWN}
    : 32'h00000000;

  // Mode decode
  // Bit 0 of the selector marks the two PWM families
  // Low bits 11: single-slope fast PWM, codes 3 and 7
  // Low bits 01: dual-slope phase PWM, codes 1 and 5
  // Code 2 clears on compare A; 0, 4 and 6 run as normal mode
  // Upper bit picks compare A as top in both PWM families
  // Output actions only shape the waveform, never the count

  // Mode classes; the action selector is never read here
  wire [2:0]   mode   = ctrl_q.waveform_mode_sel;
  wire         pwm    = mode[0];
  wire         fast   = mode[1:0] == timer8_pkg::MODE_FAST_MAX[1:0];
  wire         phase  = mode[1:0] == timer8_pkg::MODE_PHASE_MAX[1:0];
  wire         clear_on_match_mode    = mode == timer8_pkg::MODE_CTC;
  wire         going_up = dir_q == timer8_pkg::DIR_UP;

  // Top is max, or active compare A in upper-bit PWM modes
  wire [7:0]   top = (pwm & mode[2]) ? act_q[0]
                   : timer8_pkg::CNT_MAX;

  // Tick qualification
  // The tick is a one-cycle enable from the prescaler, same clock
  // A count write in the same cycle wins: no count, no clear,
  // no flag and no match on that edge
  // block_q then masks matches on the next tick as well, so a
  // count loaded equal to the compare does not fire at once
  // Hazard: writing the compare value into the count loses
  // that match for one period

  // A processor write to the count suppresses all tick work
  wire         tick_go = timer_tick & ~cnt_wr;
  wire         at_top  = count_value_q == top;
  wire         at_bot  = count_value_q == timer8_pkg::CNT_BOTTOM;
  wire         wrap_evt = tick_go & fast & at_top;
  wire         top_evt  = tick_go & phase & going_up & at_top;
  wire         bot_evt  = tick_go & phase & ~going_up & at_bot;

  // Buffer copy at bottom for fast PWM, at top for phase PWM
  wire         upd_evt = wrap_evt | top_evt;

  // Count sequence per family
  // Normal and code 2 count up; code 2 clears on compare A
  // A compare A below the count is missed until the wrap
  // Fast PWM runs bottom to top, then clears on the next tick
  // Phase PWM runs up to top, holds it one tick, then down
  // At bottom it turns again, so bottom also lasts one tick
  // A zero top in phase PWM parks the count at zero
  // Direction returns to up on each tick outside phase PWM, so a
  // later switch after such a tick starts on the up slope

  // Counter sequencing
  always_comb begin
    count_value_d = count_value_q;
    dir_d         = dir_q;
    if (cnt_wr) begin
      count_value_d = pwdata[7:0];
    end else if (timer_tick) begin
      if (phase) begin
        if (going_up) begin
          if (at_top) begin
            // Reverse; top was held for exactly this one tick
            dir_d = timer8_pkg::DIR_DOWN;
            count_value_d = at_bot ? count_value_q
                                   : count_value_q - timer8_pkg::CNT_ONE;
          end else begin
            count_value_d = count_value_q + timer8_pkg::CNT_ONE;
          end
        end else if (at_bot) begin
          // 255 up plus 255 down gives 510 ticks per period
          dir_d = timer8_pkg::DIR_UP;
          count_value_d = (top == timer8_pkg::CNT_BOTTOM) ? count_value_q
                                                          : timer8_pkg::CNT_ONE;
        end else begin
          count_value_d = count_value_q - timer8_pkg::CNT_ONE;
        end
      end else begin
        dir_d = timer8_pkg::DIR_UP;
        if ((fast & at_top) | (clear_on_match_mode & (count_value_q == cmp_eff[0]))) begin
          // Fast: 256 ticks per period at fixed top
          count_value_d = timer8_pkg::CNT_BOTTOM;
        end else begin
          // A compare below the count is passed by; wrap from max
          count_value_d = count_value_q + timer8_pkg::CNT_ONE;
        end
      end
    end
  end

  // Flag timing
  // Overflow outside PWM: on the tick that takes max to zero
  // Fast PWM: on the tick at top, the wrap tick
  // Phase PWM: on the turning tick at bottom
  // Compare flags come one tick after the match, via pend_q
  // Write-one or a service acknowledge clears a flag, but a
  // set in the same cycle wins so no event is lost

  // Flags: hardware set wins over a clear in the same cycle
  always_comb begin
    flags_d = flags_q & ~flag_service_ack;
    if (flag_wr) begin
      flags_d = flags_d & ~pwdata[2:0];
    end
    if (tick_go & ((~pwm & (count_value_q == timer8_pkg::CNT_MAX))
                   | wrap_evt
                   | bot_evt)) begin
      flags_d[timer8_pkg::FLAG_OVF] = 1'b1;
    end
    if (tick_go & pend_q[0]) begin
      flags_d[timer8_pkg::FLAG_CMP_A] = 1'b1;
    end
    if (tick_go & pend_q[1]) begin
      flags_d[timer8_pkg::FLAG_CMP_B] = 1'b1;
    end
  end

  // State update
  // Everything freezes while clk_en is low, the bus slave too
  // block_q clears on the first tick after a count write,
  // unless another count write lands in that cycle

  // Counter, direction, match blocking and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= timer8_pkg::CNT_BOTTOM;
      dir_q         <= timer8_pkg::DIR_UP;
      block_q       <= 1'b0;
      flags_q       <= timer8_pkg::FLAGS_RST;
    end else if (clk_en) begin
      count_value_q <= count_value_d;
      dir_q         <= dir_d;
      flags_q       <= flags_d;
      if (cnt_wr) begin
        block_q <= 1'b1;
      end else if (timer_tick) begin
        block_q <= 1'b0;
      end
    end
  end

  // Control register
  // Force strobes above the low byte are not stored; the
  // reserved bit 3 is forced to zero so it always reads zero
  // Action changes apply at the next match, with no buffering

  // Bus slave and control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= timer8_pkg::CTRL_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (clk_en) begin
      pready_q  <= first;
      pslverr_q <= first & ~mapped;
      if (first & ~pwrite) begin
        prdata_q <= rdata;
      end
      if (ctrl_wr) begin
        ctrl_q     <= timer8_pkg::ctrl_t'(pwdata[7:0]);
        ctrl_q.pad <= 1'b0;
      end
    end
  end

  // Compare channels
  // Each channel keeps a buffer written by software and an
  // active value that the comparator uses in PWM modes
  // Outside PWM the active value follows the buffer one cycle
  // later; in PWM it is copied only at the update point, so a
  // pulse is never cut short by a mid-period write
  // Toggle in PWM exists only on channel A with the upper bit
  // set; on channel B that code holds the output
  // Forced matches update the output only, never the flags

  // Two compare channels; only channel A may toggle in PWM
  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam bit TOG_OK = (i == 0);
    wire [1:0] act = (i == 0) ? ctrl_q.output_action_a
                              : ctrl_q.output_action_b;
    wire       inv = act[0];
    wire       top_eq = cmp_eff[i] == top;
    wire       cmp_bot = cmp_eff[i] == timer8_pkg::CNT_BOTTOM;
    logic      wave_d;

    // Double buffered in PWM modes, direct otherwise
    assign cmp_eff[i] = pwm ? act_q[i] : buf_q[i];
    // A count write blocks the match on the following tick
    assign hit[i] = tick_go & ~block_q & (count_value_q == cmp_eff[i]);
    // Forced match only outside PWM; never sets the flag
    assign force_cmp[i] = ctrl_wr & ~pwm
                        & pwdata[(i == 0) ? timer8_pkg::CTRL_FORCE_A
                                          : timer8_pkg::CTRL_FORCE_B];

    // Output action summary
    // Non-PWM: set, clear or toggle on a match or a force
    // Fast PWM: level at bottom, opposite level at the match
    // Phase PWM: match level depends on the slope direction,
    // with fixes at top and bottom for the extreme values

    // Output action per mode
    always_comb begin
      wave_d = wave_q[i];
      if (!pwm) begin
        if (hit[i] | force_cmp[i]) begin
          unique case (act)
            timer8_pkg::ACT_TOGGLE: wave_d = ~wave_q[i];
            timer8_pkg::ACT_CLEAR:  wave_d = 1'b0;
            timer8_pkg::ACT_SET:    wave_d = 1'b1;
            timer8_pkg::ACT_OFF:    wave_d = wave_q[i];
          endcase
        end
      end else if (act == timer8_pkg::ACT_TOGGLE) begin
        if (TOG_OK & mode[2] & hit[i]) begin
          wave_d = ~wave_q[i];
        end
      end else if (act[1]) begin
        if (fast) begin
          // Bottom wins over a match at top: constant level at max
          if (wrap_evt) begin
            wave_d = ~inv;
          end else if (hit[i] & ~top_eq) begin
            wave_d = inv;
          end
        end else if (bot_evt) begin
          // Restore the down-slope level at bottom for symmetry
          wave_d = cmp_bot ? inv : ~inv;
        end else if (top_evt & top_eq) begin
          wave_d = ~inv;
        end else if (hit[i]) begin
          wave_d = going_up ? inv : ~inv;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        buf_q[i]  <= timer8_pkg::CMP_RST;
        act_q[i]  <= timer8_pkg::CMP_RST;
        wave_q[i] <= 1'b0;
        pend_q[i] <= 1'b0;
      end else if (clk_en) begin
        if (wr & sel_cmp[i]) begin
          buf_q[i] <= pwdata[7:0];
        end
        if (~pwm | upd_evt) begin
          act_q[i] <= buf_q[i];
        end
        if (timer_tick) begin
          pend_q[i] <= hit[i];
        end
        wave_q[i] <= wave_d;
      end
    end
  end

  // Output summary
  // Waveforms reset low and change only on ticks or forces
  // Flags are sticky levels mirroring the flag register
  // Read data holds until the next read completes

  // Outputs straight from flops
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign wave_out_a     = wave_q[0];
  assign wave_out_b     = wave_q[1];
  assign overflow_flag  = flags_q[timer8_pkg::FLAG_OVF];
  assign compare_a_flag = flags_q[timer8_pkg::FLAG_CMP_A];
  assign compare_b_flag = flags_q[timer8_pkg::FLAG_CMP_B];

endmodule : timer8_waveform_modes

// File: test/apb_core_model.sv
module apb_core_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // One transfer held until pready; rsp[1] marks a slave that never answered
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [1:0] rsp);
    rsp = 2'h2;
    rd = '0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (pready) begin
        rd = prdata;
        rsp = {1'b0, pslverr};
        break;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_core_model

// File: test/timer8_assertions.sv
module timer8_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        timer_tick,
  input wire logic [2:0]  flag_service_ack,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        wave_out_a,
  input wire logic        overflow_flag,
  input wire logic        compare_a_flag
);
  // Decoded events; a bus write lands only when the slave is not frozen
  wire logic tick_t  = clk_en && timer_tick;
  wire logic bus_wr  = psel && penable && pready && pwrite && clk_en;
  wire logic flg_wr  = bus_wr && paddr == timer8_pkg::OFF_FLAGS;
  wire logic ctrl_wr = bus_wr && paddr == timer8_pkg::OFF_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ovf_set; $rose(overflow_flag) |-> $past(tick_t); endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("ovf rose off tick");
  property p_ovf_clr; $fell(overflow_flag) |-> $past(clk_en && (flag_service_ack[0] || flg_wr && pwdata[0])); endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("ovf cleared without cause");
  property p_cmpa_set; $rose(compare_a_flag) |-> $past(tick_t); endproperty
  a_cmpa_set: assert property (p_cmpa_set) else $error("cmp a rose off tick");
  property p_cmpa_hold; compare_a_flag && !flag_service_ack[1] && !flg_wr |=> compare_a_flag; endproperty
  a_cmpa_hold: assert property (p_cmpa_hold) else $error("cmp a not sticky");
  property p_wave; $changed(wave_out_a) |-> $past(tick_t || ctrl_wr); endproperty
  a_wave: assert property (p_wave) else $error("wave a moved off tick");
  property p_freeze; !clk_en |=> $stable({wave_out_a, overflow_flag, compare_a_flag, pready}); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  // Bus handshake: one wait state, one-cycle ready
  property p_lat; psel && !penable && clk_en ##1 psel && penable && clk_en |=> pready; endproperty
  a_lat: assert property (p_lat) else $error("ready late");
  property p_pulse; pready && clk_en |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  c_ovf: cover property ($rose(overflow_flag));
  c_cmpa: cover property ($rose(compare_a_flag));
  c_ctrl: cover property (ctrl_wr);
endmodule : timer8_checker

bind timer8_waveform_modes timer8_checker chk_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .timer_tick(timer_tick), .flag_service_ack(flag_service_ack), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .wave_out_a(wave_out_a), .overflow_flag(overflow_flag),
  .compare_a_flag(compare_a_flag));

// File: test/timer8_waveform_modes_tb.sv
module timer8_waveform_modes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, clk_en, timer_tick, psel, penable, pwrite;
  logic        pready, pslverr, wave_out_a, wave_out_b, overflow_flag, compare_a_flag, compare_b_flag;
  logic [2:0]  flag_service_ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  rsp;
  logic [7:0]  ctl [6] = '{8'hB3, 8'hE3, 8'h67, 8'hB1, 8'hA1, 8'h35};
  logic [7:0]  ka [6] = '{8'h00, 8'hFF, 8'h40, 8'hFF, 8'h00, 8'h40};
  int          seed = 32'h1397FD85;
  int          err_total, comparisons;

  always #20 pclk = ~pclk;

  timer8_waveform_modes dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .timer_tick(timer_tick),
    .flag_service_ack(flag_service_ack), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
    .compare_b_flag(compare_b_flag));
  apb_core_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Single exit for normal end and stuck bus
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus access, then settle to the falling edge so outputs are stable
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    m.xfer(w, a, d, rd, rsp);
    if (rsp[1]) begin
      err_total++;
      report_and_stop();
    end
    @(negedge pclk);
  endtask : xf

  // One timer step; sometimes the enable is low first, so the tick must wait
  task automatic tick(input logic [2:0] ack);
    int r;
    r = $random(seed);
    @(posedge pclk);
    clk_en <= (r[1:0] != 2'h0);
    timer_tick <= 1'b1;
    flag_service_ack <= ack;
    @(posedge pclk);
    if (r[1:0] == 2'h0) begin
      clk_en <= 1'b1;
      @(posedge pclk);
    end
    timer_tick <= 1'b0;
    flag_service_ack <= 3'h0;
    @(negedge pclk);
  endtask : tick

  // Output level after a step from o to n; hold and toggle depend on the old level
  function automatic logic exp_out(input logic [2:0] md, input logic [1:0] act, input logic [7:0] k, o, n,
                                   input logic p);
    if (!act[1]) return (act[0] && md[2] && o == k) ? !p : p;
    return act[0] ^ (md[1] ? (n <= k) : (n < k || (n == k && n > o)));
  endfunction : exp_out

  initial begin
    logic [7:0] a, b, k, o, c, top;
    logic [2:0] md;
    logic       up, uo, pa, pb, p;
    int         r;
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    timer_tick = 1'b0;
    flag_service_ack = 3'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (a = 8'h00; a <= 8'h18; a += 8'h04) begin
      xf(1'b0, a, 32'h0);
      chk("read", 32'h0, rd);
      chk("slverr", a == 8'h18, rsp[0]);
    end
    $display("Test reset_regs done");
    xf(1'b1, timer8_pkg::OFF_COUNT, 32'hFD);
    repeat (2) tick(3'h0);
    xf(1'b0, timer8_pkg::OFF_COUNT, 32'h0);
    chk("count", 32'hFF, rd);
    chk("ovf", 32'h0, overflow_flag);
    tick(3'h0);
    chk("ovf", 32'h1, overflow_flag);
    xf(1'b0, timer8_pkg::OFF_COUNT, 32'h0);
    chk("count", 32'h0, rd);
    xf(1'b1, timer8_pkg::OFF_FLAGS, 32'h1);
    chk("ovf", 32'h0, overflow_flag);
    $display("Test normal_wrap done");
    r = $random(seed);
    k = 8'h02 + 8'(r[2:0]);
    xf(1'b1, timer8_pkg::OFF_CTRL, 32'h42);
    xf(1'b1, timer8_pkg::OFF_CMP_A, {24'h0, k});
    xf(1'b1, timer8_pkg::OFF_COUNT, 32'h0);
    xf(1'b1, timer8_pkg::OFF_FLAGS, 32'h7);
    p = wave_out_a;
    for (int i = 1; i <= 3 * (k + 1); i++) begin
      tick(3'h0);
      chk("wave_a", p ^ ((i / (k + 1)) % 2), wave_out_a);
      chk("cmp_a", i >= k + 2, compare_a_flag);
      chk("cmp_b", i >= k + 3, compare_b_flag);
    end
    tick(3'h0);
    xf(1'b1, timer8_pkg::OFF_FLAGS, 32'h2);
    xf(1'b1, timer8_pkg::OFF_COUNT, {24'h0, k});
    repeat (2) tick(3'h0);
    chk("wave_a", p ^ 1'b1, wave_out_a);
    chk("cmp_a", 32'h0, compare_a_flag);
    xf(1'b1, timer8_pkg::OFF_COUNT, 32'h10);
    xf(1'b1, timer8_pkg::OFF_FLAGS, 32'h1);
    for (int i = 1; i <= 240; i++) begin
      tick(3'h0);
      chk("wave_a", p ^ 1'b1, wave_out_a);
      chk("ovf", i == 240, overflow_flag);
    end
    $display("Test clear_on_match done");
    // PWM rows: first 510 ticks settle the outputs, the next 510 are checked
    for (int j = 0; j < 6; j++) begin
      r = $random(seed);
      a = (ka[j] == 8'h40) ? (8'h40 | {2'h0, r[5:0]}) : ka[j];
      b = r[15:8];
      md = ctl[j][2:0];
      top = md[2] ? a : 8'hFF;
      xf(1'b1, timer8_pkg::OFF_CTRL, 32'h0);
      xf(1'b1, timer8_pkg::OFF_CMP_A, {24'h0, a});
      xf(1'b1, timer8_pkg::OFF_CMP_B, {24'h0, b});
      xf(1'b1, timer8_pkg::OFF_COUNT, 32'h0);
      xf(1'b1, timer8_pkg::OFF_CTRL, {24'h0, ctl[j]});
      xf(1'b0, timer8_pkg::OFF_STATUS, 32'h0);
      up = !rd[0];
      c = 8'h00;
      for (int i = 1; i <= 1020; i++) begin
        o = c;
        uo = up;
        if (md[1]) c = (o == top) ? 8'h00 : o + 8'h01;
        else if (up && o == top) {up, c} = {1'b0, o - 8'h01};
        else if (!up && o == 8'h00) {up, c} = {1'b1, 8'h01};
        else c = up ? o + 8'h01 : o - 8'h01;
        if (i <= 510) {pa, pb} = {wave_out_a, wave_out_b};
        tick(3'h7);
        pa = exp_out(md, ctl[j][7:6], a, o, c, pa);
        pb = exp_out(md, ctl[j][5:4], b, o, c, pb);
        if (i > 510) begin
          chk("wave_a", pa, wave_out_a);
          chk("wave_b", pb, wave_out_b);
          chk("ovf", md[1] ? o == top : !uo && o == 8'h00, overflow_flag);
        end
      end
      $display("Test pwm_row %0d done", j);
    end
    report_and_stop();
  end
endmodule : timer8_waveform_modes_tb
